/* File: hdl/rbd_regs.vh */
// Register map, descriptor layout and encodings of the receive buffer
// descriptor handler. Definitions only; included by its bare name.
`ifndef RBD_REGS_VH
`define RBD_REGS_VH

// APB register byte offsets
`define RBD_CTRL_OFS 8'h00
`define RBD_BASE_OFS 8'h04
`define RBD_LIST_OFS 8'h08
`define RBD_STAT_OFS 8'h0c
`define RBD_CUR_OFS 8'h10

// Control register fields
`define RBD_CTRL_START 0
`define RBD_CTRL_MODE_LO 1
`define RBD_CTRL_MODE_HI 2
`define RBD_CTRL_PFEN 3
`define RBD_CTRL_RST 32'h0000_0000

// Memory modes
`define RBD_MODE_LEGACY 2'h0
`define RBD_MODE_SEGMENT 2'h1
`define RBD_MODE_LINEAR 2'h2

// Descriptor word byte offsets in memory
`define RBD_W_STATUS 32'h0000_0000
`define RBD_W_LINK 32'h0000_0004
`define RBD_W_BUFADR 32'h0000_0008
`define RBD_W_SIZE 32'h0000_000c

// Descriptor field positions
`define RBD_CNT_HI 13
`define RBD_EOF_BIT 14
`define RBD_USED_BIT 15
`define RBD_SIZE_HI 13
`define RBD_PF_BIT 14
`define RBD_EL_BIT 15

// Status register fields
`define RBD_STAT_NORES 0
`define RBD_STAT_BUSY 1
`define RBD_STAT_FRM_LO 16

`endif

/* File: hdl/rbd_handler.v */
// Receive buffer descriptor handler: walks the free buffer list in shared
// memory, fills buffers from the receive stream and writes descriptors back.
// Assumes a memory port that holds each request until it acknowledges it,
// and an APB master for configuration. One clock, pclk.
`timescale 1ns/1ns
`default_nettype none
`include "rbd_regs.vh"

// Data FIFO between the receive stream and the memory writer
module rbd_fifo #(
    parameter WIDTH = 18,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk,
    input wire rst_n,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] cnt_reg;
    reg in_ready_reg;
    reg empty_reg;
    wire push = in_valid & in_ready_reg;
    wire pop = out_ready & ~empty_reg;
    wire [AW:0] cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    // Ready is a flop of its own so the top port comes straight from one
    assign in_ready = in_ready_reg;
    assign out_valid = ~empty_reg;
    assign out_data = mem[rd_ptr_reg];

    // Storage; no reset needed, empty flag guards stale words
    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers and registered full/empty flags
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
            in_ready_reg <= 1'b1;
            empty_reg <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == DEPTH - 1) ? {AW{1'b0}} :
                    wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == DEPTH - 1) ? {AW{1'b0}} :
                    rd_ptr_reg + 1'b1;
            end
            cnt_reg <= cnt_next;
            in_ready_reg <= (cnt_next != DEPTH);
            empty_reg <= (cnt_next == {(AW+1){1'b0}});
        end
    end
endmodule // rbd_fifo

// Function
// - Write last-buffer flag in the descriptor of the frame's final bytes.
// - Set used flag after finishing a buffer; byte count valid only then.
// - Write 14-bit byte count: size when full, may be less when last.
// - Follow link as offset, or absolute in linear mode; ignore at end.
// - Buffer address is 24 bits with upper bits zero in legacy mode.
// - A descriptor with end_of_list_flag set holds the list's final buffer.
// - With prefetch marking, read descriptor locked, rewrite with flag set; legacy mode does neither.
// - Set prefetched flag blindly; host clears it in all descriptors.
// - Never overfill a buffer; fetch each next descriptor ahead of need.
// - On free list exhaustion the receive unit enters no-resources state.
module rbd_handler #(
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW = 3
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg mem_req,
    output reg mem_we,
    output reg mem_lock,
    output reg [31:0] mem_addr,
    output reg [3:0] mem_be,
    output reg [31:0] mem_wdata,
    input wire mem_ack,
    input wire [31:0] mem_rdata,
    input wire rx_valid,
    input wire [15:0] rx_data,
    input wire rx_last,
    input wire rx_odd,
    output wire rx_ready,
    output reg no_resources
);
    localparam S_IDLE = 6'h01;
    localparam S_FETCH = 6'h02;
    localparam S_MARK = 6'h04;
    localparam S_FILL = 6'h08;
    localparam S_WBACK = 6'h10;
    localparam S_NORES = 6'h20;

    reg [5:0] state_reg;
    reg [1:0] mode_reg;
    reg pf_en_reg;
    reg [31:0] base_reg;
    reg [31:0] list_reg;
    reg [31:0] cur_reg;
    reg [31:0] link_reg;
    reg [31:0] bufadr_reg;
    reg [31:0] size_w_reg;
    reg [1:0] idx_reg;
    reg [14:0] cnt_reg;
    reg last_reg;
    reg [15:0] frames_reg;

    wire [17:0] fifo_dout;
    wire fifo_valid;
    wire [14:0] size15 = {1'b0, size_w_reg[`RBD_SIZE_HI:0]};
    wire [14:0] step = fifo_dout[16] ? 15'h0001 : 15'h0002;
    reg mem_last_odd_reg;
    wire [14:0] cnt_sum = cnt_reg + (mem_last_odd_reg ? 15'h0001 : 15'h0002);
    wire lock_mode = pf_en_reg & (mode_reg != `RBD_MODE_LEGACY);
    wire setup = psel & ~penable;
    wire wr_ctrl = setup & pwrite & (paddr == `RBD_CTRL_OFS);
    wire start = wr_ctrl & pwdata[`RBD_CTRL_START];
    // Lock choice of the first fetch comes from the start word itself; the
    // mode and enable registers only take that word at the same edge
    wire start_lock = pwdata[`RBD_CTRL_PFEN] &
        (pwdata[`RBD_CTRL_MODE_HI:`RBD_CTRL_MODE_LO] != `RBD_MODE_LEGACY);
    wire room = (cnt_reg + step) <= size15;
    wire fifo_pop = (state_reg == S_FILL) & ~mem_req & fifo_valid & room;

    // Next descriptor: offset from base, or absolute in linear mode
    function [31:0] next_addr;
        input [1:0] mode;
        input [31:0] base;
        input [31:0] link;
        begin
            if (mode == `RBD_MODE_LINEAR) begin
                next_addr = link;
            end else begin
                next_addr = base + {16'h0000, link[15:0]};
            end
        end
    endfunction

    // Buffer start: legacy mode keeps 24 bits, upper lines zero
    function [31:0] buf_base;
        input [1:0] mode;
        input [31:0] adr;
        begin
            if (mode == `RBD_MODE_LEGACY) begin
                buf_base = {8'h00, adr[23:0]};
            end else begin
                buf_base = adr;
            end
        end
    endfunction

    // Receive data waits here; a stalled memory side backs up to rx_ready
    rbd_fifo #(
        .WIDTH(18),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clk(pclk),
        .rst_n(presetn),
        .in_valid(rx_valid),
        .in_ready(rx_ready),
        .in_data({rx_last, rx_odd, rx_data}),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_dout)
    );

    // APB slave: no wait states, registered answer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            mode_reg <= 2'h0;
            pf_en_reg <= 1'b0;
            base_reg <= 32'h0000_0000;
            list_reg <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= 1'b0;
            if (setup) begin
                prdata <= 32'h0000_0000;
                case (paddr)
                `RBD_CTRL_OFS: begin
                    prdata <= {28'h0000000, pf_en_reg, mode_reg, 1'b0};
                    if (pwrite) begin
                        mode_reg <= pwdata[`RBD_CTRL_MODE_HI:
                            `RBD_CTRL_MODE_LO];
                        pf_en_reg <= pwdata[`RBD_CTRL_PFEN];
                    end
                end
                `RBD_BASE_OFS: begin
                    prdata <= base_reg;
                    if (pwrite) begin
                        base_reg <= pwdata;
                    end
                end
                `RBD_LIST_OFS: begin
                    prdata <= list_reg;
                    if (pwrite) begin
                        list_reg <= pwdata;
                    end
                end
                `RBD_STAT_OFS: begin
                    prdata <= {frames_reg, 14'h0000,
                        ~(state_reg == S_IDLE) & ~no_resources, no_resources};
                end
                `RBD_CUR_OFS: begin
                    prdata <= cur_reg;
                end
                default: begin
                    pslverr <= 1'b1; // Unmapped address
                end
                endcase
            end
        end
    end

    // Descriptor walker
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= S_IDLE;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_lock <= 1'b0;
            mem_addr <= 32'h0000_0000;
            mem_be <= 4'h0;
            mem_wdata <= 32'h0000_0000;
            no_resources <= 1'b0;
            cur_reg <= 32'h0000_0000;
            link_reg <= 32'h0000_0000;
            bufadr_reg <= 32'h0000_0000;
            size_w_reg <= 32'h0000_0000;
            idx_reg <= 2'h0;
            cnt_reg <= 15'h0000;
            last_reg <= 1'b0;
            mem_last_odd_reg <= 1'b0;
            frames_reg <= 16'h0000;
        end else begin
            case (state_reg)
            S_IDLE, S_NORES: begin
                // Start relies on the host having cleared the list
                if (start) begin
                    no_resources <= 1'b0;
                    cur_reg <= list_reg;
                    idx_reg <= 2'h1;
                    mem_req <= 1'b1;
                    mem_we <= 1'b0;
                    mem_be <= 4'hf;
                    mem_lock <= start_lock;
                    mem_addr <= list_reg + `RBD_W_LINK;
                    state_reg <= S_FETCH;
                end
            end
            S_FETCH: begin
                if (mem_ack) begin
                    case (idx_reg)
                    2'h1: link_reg <= mem_rdata;
                    2'h2: bufadr_reg <= buf_base(mode_reg, mem_rdata);
                    default: size_w_reg <= mem_rdata;
                    endcase
                    if (idx_reg == 2'h3) begin
                        cnt_reg <= 15'h0000;
                        if (mem_lock) begin
                            // Set without looking at the old flag
                            mem_we <= 1'b1;
                            mem_addr <= cur_reg + `RBD_W_SIZE;
                            mem_wdata <= mem_rdata | 32'h0000_4000;
                            state_reg <= S_MARK;
                        end else begin
                            mem_req <= 1'b0;
                            state_reg <= S_FILL;
                        end
                    end else begin
                        idx_reg <= idx_reg + 2'h1;
                        mem_addr <= mem_addr + 32'h0000_0004;
                    end
                end
            end
            S_MARK: begin
                if (mem_ack) begin
                    mem_req <= 1'b0;
                    mem_we <= 1'b0;
                    mem_lock <= 1'b0;
                    state_reg <= S_FILL;
                end
            end
            S_FILL: begin
                if (mem_req & mem_ack) begin
                    cnt_reg <= cnt_sum;
                    if (last_reg | (cnt_sum >= size15)) begin
                        // Buffer done: count, used and last flags
                        mem_addr <= cur_reg + `RBD_W_STATUS;
                        mem_be <= 4'hf;
                        mem_wdata <= {16'h0000, 1'b1, last_reg,
                            cnt_sum[`RBD_CNT_HI:0]};
                        if (last_reg) begin
                            frames_reg <= frames_reg + 16'h0001;
                        end
                        state_reg <= S_WBACK;
                    end else begin
                        mem_req <= 1'b0;
                    end
                end else if (~mem_req & ~room) begin
                    // Zero size or no room for the next word: never write past size
                    mem_req <= 1'b1;
                    mem_we <= 1'b1;
                    mem_addr <= cur_reg + `RBD_W_STATUS;
                    mem_be <= 4'hf;
                    mem_wdata <= {16'h0000, 1'b1, 1'b0,
                        cnt_reg[`RBD_CNT_HI:0]};
                    state_reg <= S_WBACK;
                end else if (fifo_pop) begin
                    mem_req <= 1'b1;
                    mem_we <= 1'b1;
                    mem_addr <= bufadr_reg + {17'h00000, cnt_reg};
                    mem_wdata <= {fifo_dout[15:0], fifo_dout[15:0]};
                    mem_be <= bufadr_reg[1] ^ cnt_reg[1] ?
                        (fifo_dout[16] ? 4'h4 : 4'hc) :
                        (fifo_dout[16] ? 4'h1 : 4'h3);
                    last_reg <= fifo_dout[17];
                    mem_last_odd_reg <= fifo_dout[16];
                end
            end
            S_WBACK: begin
                if (mem_ack) begin
                    last_reg <= 1'b0;
                    if (size_w_reg[`RBD_EL_BIT]) begin
                        // Final buffer of the list; link ignored
                        mem_req <= 1'b0;
                        mem_we <= 1'b0;
                        no_resources <= 1'b1;
                        state_reg <= S_NORES;
                    end else begin
                        // Fetch ahead of the data that will need it
                        cur_reg <= next_addr(mode_reg, base_reg, link_reg);
                        idx_reg <= 2'h1;
                        mem_we <= 1'b0;
                        mem_lock <= lock_mode;
                        mem_addr <= next_addr(mode_reg, base_reg, link_reg) +
                            `RBD_W_LINK;
                        state_reg <= S_FETCH;
                    end
                end
            end
            default: begin
                state_reg <= S_IDLE;
            end
            endcase
        end
    end
endmodule // rbd_handler
`default_nettype wire

/* File: tb/rbd_handler_sva.sv */
// Port checker for the descriptor handler.
// Assumes one clock, pclk, and the active-low reset presetn.
`timescale 1ns/1ns
`default_nettype none
module rbd_sva (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire mem_req,
    input wire mem_we,
    input wire mem_lock,
    input wire [31:0] mem_addr,
    input wire [3:0] mem_be,
    input wire [31:0] mem_wdata,
    input wire mem_ack,
    input wire [31:0] mem_rdata,
    input wire no_resources
);
    reg [31:0] flags_reg;
    reg [1:0] mode_reg;
    reg el_reg;
    wire desc_rd = mem_req && mem_ack && !mem_we && mem_addr[3:0] == 4'hc;
    // Control writes are taken at the setup edge, as in the slave
    wire ctrl_wr = psel && !penable && pwrite && paddr == 8'h00;
    // Last flags word fetched, mode in force, end of list seen since start
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= 32'h0;
            mode_reg <= 2'h0;
            el_reg <= 1'b0;
        end else begin
            if (desc_rd)
                flags_reg <= mem_rdata;
            if (desc_rd && mem_rdata[15])
                el_reg <= 1'b1;
            else if (ctrl_wr && pwdata[0])
                el_reg <= 1'b0;
            if (ctrl_wr)
                mode_reg <= pwdata[2:1];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_apb_ans;
        psel && !penable |=> pready;
    endproperty
    a_apb_ans: assert property (p_apb_ans) else $error("apb answer late");
    property p_unmapped;
        psel && !penable && paddr > 8'h10 |=> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("no slave error");
    property p_mem_hold;
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
            && $stable(mem_we) && $stable(mem_wdata);
    endproperty
    a_mem_hold: assert property (p_mem_hold) else $error("request dropped");
    property p_stat_fmt;
        mem_req && mem_we && mem_be == 4'hf && mem_addr[3:0] == 4'h0
            |-> mem_wdata[31:15] == 17'h1;
    endproperty
    a_stat_fmt: assert property (p_stat_fmt) else $error("bad status");
    property p_pf_wb;
        mem_req && mem_we && mem_lock |-> mem_addr[3:0] == 4'hc
            && mem_wdata == (flags_reg | 32'h0000_4000);
    endproperty
    a_pf_wb: assert property (p_pf_wb) else $error("bad mark");
    property p_lock_mode;
        mem_lock |-> mode_reg != 2'h0;
    endproperty
    a_lock_mode: assert property (p_lock_mode) else $error("lock");
    property p_lock_end;
        $fell(mem_lock) |-> $past(mem_ack && mem_we);
    endproperty
    a_lock_end: assert property (p_lock_end) else $error("unlock");
    property p_legacy;
        mem_req && mem_we && mem_be != 4'hf && mode_reg == 2'h0
            |-> mem_addr[31:24] == 8'h0;
    endproperty
    a_legacy: assert property (p_legacy) else $error("high address");
    property p_nores;
        $rose(no_resources) |-> el_reg && !mem_req;
    endproperty
    a_nores: assert property (p_nores) else $error("early stop");
endmodule // rbd_sva
bind rbd_handler rbd_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .mem_req, .mem_we,
    .mem_lock, .mem_addr, .mem_be, .mem_wdata, .mem_ack, .mem_rdata,
    .no_resources);
`default_nettype wire

/* File: tb/rbd_mem_model.sv */
// Shared memory behind the handler's bus master port.
// Word array; the bench loads and inspects it directly.
`timescale 1ns/1ns
`default_nettype none
module rbd_mem_model (
    input wire pclk,
    input wire presetn,
    input wire slow,
    input wire mem_req,
    input wire mem_we,
    input wire [31:0] mem_addr,
    input wire [3:0] mem_be,
    input wire [31:0] mem_wdata,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [31:0] m [int unsigned];
    int wait_cnt;
    int b;
    // One ack per request; slow mode adds 0 to 3 waits so the FIFO fills
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            mem_rdata <= 32'h0;
            wait_cnt <= 0;
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack && wait_cnt > 0)
                wait_cnt <= wait_cnt - 1;
            else if (mem_req && !mem_ack) begin
                mem_ack <= 1'b1;
                wait_cnt <= slow ? $urandom_range(0, 3) : 0;
                if (!mem_we)
                    mem_rdata <= m[mem_addr >> 2];
                for (b = 0; b < 4; b++)
                    if (mem_we && mem_be[b])
                        m[mem_addr >> 2][8*b +: 8] = mem_wdata[8*b +: 8];
            end
        end
    end
endmodule // rbd_mem_model
`default_nettype wire

/* File: tb/tb.sv */
// Bench for the descriptor handler: APB setup, descriptors in the
// memory model, random frames on the receive stream in every mode.
`timescale 1ns/1ns
`default_nettype none
`include "rbd_regs.vh"
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic rx_valid = 1'b0;
    logic [15:0] rx_data = 16'h0;
    logic rx_last = 1'b0;
    logic rx_odd = 1'b0;
    logic slow = 1'b0;
    wire [31:0] prdata, mem_addr, mem_wdata, mem_rdata;
    wire pready, pslverr, mem_req, mem_we, mem_lock, mem_ack;
    wire [3:0] mem_be;
    wire rx_ready, no_resources;
    int err_count = 0;
    int compares = 0;
    int len, cap, k;
    logic [31:0] r, flg, dsc [3], sz [3], bufa [3];
    logic e;
    logic [7:0] fb [64];
    // Clock of 100 ns
    always #50 pclk = ~pclk;
    rbd_handler #(.FIFO_DEPTH(8), .FIFO_AW(3)) dut (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .mem_req, .mem_we, .mem_lock, .mem_addr, .mem_be, .mem_wdata,
        .mem_ack, .mem_rdata, .rx_valid, .rx_data, .rx_last, .rx_odd,
        .rx_ready, .no_resources);
    rbd_mem_model u_mem (.pclk, .presetn, .slow, .mem_req, .mem_we,
        .mem_addr, .mem_be, .mem_wdata, .mem_ack, .mem_rdata);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One byte of the memory model, zero-extended
    function automatic logic [31:0] mem_byte(input logic [31:0] ad);
        logic [31:0] w;
        w = u_mem.m[ad >> 2];
        return {24'h0, w[8*ad[1:0] +: 8]};
    endfunction
    // APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] ad,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Stream word; valid stays up so back-to-back words need no gap
    task automatic send(input logic [15:0] d, input logic l, input logic o);
        rx_valid <= 1'b1;
        rx_data <= d;
        rx_last <= l;
        rx_odd <= o;
        @(posedge pclk);
        while (rx_ready !== 1'b1)
            @(posedge pclk);
    endtask
    task automatic final_report;
        $display("err_count %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Cut a hang short; six frames need far less than this
    initial begin
        #(100 * 50000);
        err_count++;
        final_report;
    end
    // Main sequence
    initial begin
        void'($urandom(83));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `RBD_STAT_OFS, 32'h0);
        chk(r, 32'h0);
        chk({31'h0, rx_ready}, 32'h1);
        for (int w = 0; w < 2; w++) begin
            apb(w[0], 8'h14, 32'hffff_ffff);
            chk({31'h0, e}, 32'h1);
            chk(r, 32'h0);
        end
        for (int run = 0; run < 6; run++) begin
            logic [1:0] mode;
            logic pf;
            mode = 2'(run % 3);
            pf = run >= 3;
            slow <= run[0];
            // Host prepares a three-entry list, fields cleared, even sizes
            for (int i = 0; i < 3; i++) begin
                dsc[i] = 32'h0001_0000 + 32'h100 * (i + 1);
                sz[i] = 2 * $urandom_range(1, 8);
                bufa[i] = 32'h0002_0000 + 32'h100 * i;
                u_mem.m[dsc[i] >> 2] = 32'h0;
                u_mem.m[(dsc[i] >> 2) + 1] = 32'h100 * (i + 2)
                    + (mode == 2 ? 32'h0001_0000 : 32'h0);
                u_mem.m[(dsc[i] >> 2) + 2] = bufa[i]
                    | (mode == 0 ? 32'hab00_0000 : 32'h0);
                u_mem.m[(dsc[i] >> 2) + 3] = (i == 2 ? 32'h8000 : 32'h0)
                    | sz[i];
                u_mem.m[(bufa[i] + sz[i]) >> 2] = 32'h0;
            end
            len = sz[0] + sz[1] + (run == 1 ? sz[2] : $urandom_range(1, sz[2]));
            foreach (fb[j])
                fb[j] = 8'($urandom);
            apb(1'b1, `RBD_BASE_OFS, 32'h0001_0000);
            apb(1'b1, `RBD_LIST_OFS, dsc[0]);
            apb(1'b1, `RBD_CTRL_OFS, {28'h0, pf, mode, 1'b1});
            for (int j = 0; j < len; j += 2) begin
                if ($urandom_range(0, 3) == 0) begin
                    rx_valid <= 1'b0;
                    @(posedge pclk);
                end
                send({fb[j + 1], fb[j]}, j + 2 >= len, j + 1 == len);
            end
            rx_valid <= 1'b0;
            for (k = 0; k < 3000 && no_resources !== 1'b1; k++)
                @(posedge pclk);
            chk({31'h0, no_resources}, 32'h1);
            apb(1'b0, `RBD_STAT_OFS, 32'h0);
            chk({30'h0, r[1:0]}, 32'h1);
            chk({16'h0, r[31:16]}, run + 1);
            apb(1'b0, `RBD_CUR_OFS, 32'h0);
            chk(r, dsc[2]);
            apb(1'b0, `RBD_CTRL_OFS, 32'h0);
            chk(r, {28'h0, pf, mode, 1'b0});
            // Each buffer: status, flags, bytes in place, no spill past end
            cap = 0;
            for (int i = 0; i < 3; i++) begin
                k = len - cap < sz[i] ? len - cap : sz[i];
                flg = {16'h0, 1'b1, i == 2, k[13:0]};
                chk(u_mem.m[dsc[i] >> 2], flg);
                flg = (i == 2 ? 32'h8000 : 32'h0) | sz[i];
                if (pf && mode != 2'h0)
                    flg = flg | 32'h4000;
                chk(u_mem.m[(dsc[i] >> 2) + 3], flg);
                for (int j = 0; j < k; j++) begin
                    chk(mem_byte(bufa[i] + j), {24'h0, fb[cap + j]});
                end
                chk(mem_byte(bufa[i] + sz[i]), 32'h0);
                cap = cap + sz[i];
            end
        end
        final_report;
    end
endmodule // tb
`default_nettype wire
